// [src/chan_en_pol.sv]
// Enable and polarity control for four compare/capture timer channels, APB slave.
//
// How it works
// - Enable bits of channels one to four sit at bits 0, 4, 8 and 12 and are read/write.
// - Polarity bits of channels one to four sit at bits 1, 5, 9 and 13 and are read/write.
// - In output mode a polarity of one makes the compare output active low, zero active high.
// - In input mode a polarity of one captures on the falling input edge, zero on the rising edge.
// - As an external trigger the input is inverted when polarity is one and passed when zero.
// - Polarity writes are ignored while the lock level is 2 or 3 and the old value is kept.
// - An enabled output channel routes its compare signal to the pin.
// - A disabled output channel blocks the compare signal and the pin takes its off level.
// - All enable and polarity bits reset to zero and every other bit reads zero.
`timescale 1ns/1ps
`include "chan_en_pol_params.svh"
module chan_en_pol
  import chan_en_pol_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel signals.
  input  wire chan_in_t    chan_in,
  output chan_out_t        chan_out
);

  // Register file state.
  logic [15:0] ccer_q;
  logic [15:0] ccer_d;
  logic [1:0]  lock_q;
  logic [1:0]  lock_d;
  logic [3:0]  cmode_q;
  logic [3:0]  cmode_d;

  // APB answer state.
  apb_state_t  st_q;
  apb_state_t  st_d;
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;

  // Capture pin synchronisers and the previous synchronised level.
  logic [3:0]  cap_meta_q;
  logic [3:0]  cap_meta_d;
  logic [3:0]  cap_sync_q;
  logic [3:0]  cap_sync_d;
  logic [3:0]  cap_prev_q;
  logic [3:0]  cap_prev_d;

  // Registered channel outputs.
  chan_out_t   out_q;
  chan_out_t   out_d;

  // Decode helpers.
  logic        hit_ccer;
  logic        hit_lock;
  logic        hit_cmode;
  logic        mapped;
  logic        wr_en;
  logic        locked;
  logic [15:0] wmask;
  logic [31:0] rd_val;

  // Per-channel results before the output register.
  logic [3:0]  oe_c;
  logic [3:0]  level_c;
  logic [3:0]  edge_c;
  logic [3:0]  trig_c;

  // Address decode of the three registers.
  always_comb begin
    hit_ccer  = (paddr == `CEP_REG_OFFSET);
    hit_lock  = (paddr == `CEP_LOCK_OFFSET);
    hit_cmode = (paddr == `CEP_CMODE_OFFSET);
    mapped    = hit_ccer || hit_lock || hit_cmode;
  end

  // A write takes effect at the edge at which the master samples pready high.
  // The registered pready marks that edge, so no earlier edge can change a register.
  always_comb begin
    wr_en = psel && penable && pready && pwrite && mapped;
  end

  // Once the lock level reaches two, only the enable bits of the enable and polarity register stay writable; lock and mode stay writable.
  always_comb begin
    locked = (lock_q >= `CEP_LOCK_PROTECT);
    wmask  = `CEP_WRITE_MASK;
    if (locked) begin
      wmask = `CEP_LOCKED_MASK;
    end
  end

  // Next value of the enable and polarity register; reserved bits never get set.
  always_comb begin
    ccer_d = ccer_q;
    if (wr_en && hit_ccer) begin
      ccer_d = (ccer_q & ~wmask) | (pwdata[15:0] & wmask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccer_q <= `CEP_REG_RESET;
    end else if (clk_en) begin
      ccer_q <= ccer_d;
    end
  end

  // Lock level, standing in for the lock field of the break_deadtime_register.
  always_comb begin
    lock_d = lock_q;
    if (wr_en && hit_lock) begin
      lock_d = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= `CEP_LOCK_RESET;
    end else if (clk_en) begin
      lock_q <= lock_d;
    end
  end

  // Channel mode: bit i high makes channel i+1 an input, low an output.
  // Mode selection itself lives outside this block; this register only feeds it in.
  always_comb begin
    cmode_d = cmode_q;
    if (wr_en && hit_cmode) begin
      cmode_d = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmode_q <= `CEP_CMODE_RESET;
    end else if (clk_en) begin
      cmode_q <= cmode_d;
    end
  end

  // Read data; every reserved bit and every unmapped address reads zero.
  always_comb begin
    case (paddr)
      `CEP_REG_OFFSET:   rd_val = {16'h0000, ccer_q & `CEP_WRITE_MASK};
      `CEP_LOCK_OFFSET:  rd_val = {30'h0000_0000, lock_q};
      `CEP_CMODE_OFFSET: rd_val = {28'h000_0000, cmode_q};
      default:           rd_val = 32'h0000_0000;
    endcase
  end

  // APB handshake: one wait state, answer in the cycle after the access phase starts.
  // The pready pulse lasts one cycle, so a master that holds the access phase is
  // never answered twice for the same transfer.
  always_comb begin
    st_d      = st_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata;
    case (st_q)
      ST_IDLE: begin
        if (psel && !penable) begin
          st_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (psel && penable && !pready) begin
          pready_d  = 1'b1;
          pslverr_d = !mapped;
          prdata_d  = pwrite ? 32'h0000_0000 : rd_val;
          st_d      = ST_IDLE;
        end else if (!psel) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      st_q    <= st_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // The capture pins are asynchronous: two flip-flops settle them before any logic
  // reads them, and a third keeps the previous settled level for edge detection.
  // Only the second and third stages are read by the channel logic.
  always_comb begin
    cap_meta_d = chan_in.capture_in;
    cap_sync_d = cap_meta_q;
    cap_prev_d = cap_sync_q;
  end

  // The reset level matches the idle low pin, so no false edge follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_meta_q <= 4'h0;
      cap_sync_q <= 4'h0;
      cap_prev_q <= 4'h0;
    end else if (clk_en) begin
      cap_meta_q <= cap_meta_d;
      cap_sync_q <= cap_sync_d;
      cap_prev_q <= cap_prev_d;
    end
  end

  // One slice per channel, each with its own enable and polarity bits.
  for (genvar i = 0; i < 4; i++) begin : g_chan
    chan_slice i_chan_slice (
      .en       (ccer_q[i*`CEP_CH_STRIDE + `CEP_EN_BIT0]),
      .pol      (ccer_q[i*`CEP_CH_STRIDE + `CEP_POL_BIT0]),
      .inp      (cmode_q[i]),
      .compare  (chan_in.compare[i]),
      .sync_lvl (cap_sync_q[i]),
      .prev_lvl (cap_prev_q[i]),
      .oe       (oe_c[i]),
      .level    (level_c[i]),
      .cap_edge (edge_c[i]),
      .trig     (trig_c[i])
    );
  end

  // Gather the slice results into the output carrier.
  always_comb begin
    out_d.pin_oe       = oe_c;
    out_d.pin_level    = level_c;
    out_d.capture_edge = edge_c;
    out_d.trigger      = trig_c;
  end

  // Every channel output comes straight from this register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else if (clk_en) begin
      out_q <= out_d;
    end
  end

  assign chan_out = out_q;

endmodule : chan_en_pol

// One channel: output gating and polarity, capture edge choice and trigger inversion.
// In output mode a disabled channel drives its off level of zero with the pin enable low;
// the main-output and idle-state logic that decides the final pin level sits outside.
// In input mode the enable bit gates the capture pulse, while the trigger is always made,
// since an external trigger does not depend on whether captures are allowed.
module chan_slice (
  // Channel controls.
  input  wire logic en,
  input  wire logic pol,
  input  wire logic inp,
  // Channel levels.
  input  wire logic compare,
  input  wire logic sync_lvl,
  input  wire logic prev_lvl,
  // Results.
  output logic      oe,
  output logic      level,
  output logic      cap_edge,
  output logic      trig
);

  logic rise;
  logic fall;
  logic drive_on;

  // Edges of the settled capture input.
  always_comb begin
    rise = sync_lvl && !prev_lvl;
    fall = prev_lvl && !sync_lvl;
  end

  // Output side: polarity one makes the compare output active low.
  always_comb begin
    drive_on = !inp && en;
    oe       = drive_on;
    level    = drive_on ? (compare ^ pol) : 1'b0;
  end

  // Input side: polarity one selects the falling edge and inverts the trigger.
  always_comb begin
    trig     = sync_lvl ^ pol;
    cap_edge = inp && en && (pol ? fall : rise);
  end

endmodule : chan_slice

// [src/chan_en_pol_params.svh]
// Offsets, field positions, reset values and write masks for the channel enable and polarity block.
`ifndef CHAN_EN_POL_PARAMS_SVH
`define CHAN_EN_POL_PARAMS_SVH
`define CEP_REG_OFFSET      12'h020
`define CEP_REG_RESET       16'h0000
`define CEP_WRITE_MASK      16'h3333
`define CEP_LOCKED_MASK     16'h1111
`define CEP_EN_BIT0         0
`define CEP_POL_BIT0        1
`define CEP_CH_STRIDE       4
`define CEP_LOCK_OFFSET     12'h024
`define CEP_LOCK_RESET      2'h0
`define CEP_LOCK_PROTECT    2'h2
`define CEP_CMODE_OFFSET    12'h028
`define CEP_CMODE_RESET     4'h0
`endif

// [src/chan_en_pol_pkg.sv]
// Types shared by the channel enable and polarity block.
package chan_en_pol_pkg;
  typedef struct packed {
    logic [3:0] compare;
    logic [3:0] capture_in;
  } chan_in_t;
  typedef struct packed {
    logic [3:0] pin_level;
    logic [3:0] pin_oe;
    logic [3:0] capture_edge;
    logic [3:0] trigger;
  } chan_out_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS
  } apb_state_t;
endpackage : chan_en_pol_pkg

// [tb/chan_en_pol_checker.sv]
// Port assertions for the channel enable and polarity block.
`timescale 1ns/1ps
module chan_en_pol_checker import chan_en_pol_pkg::*; (
  // APB.
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Channels.
  input wire chan_in_t  chan_in,
  input wire chan_out_t chan_out);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_wait_a: assert property (psel && !penable |-> ##2 pready) else $error("slow answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  unmapped_err_a: assert property (pready && paddr > 12'h028 |-> pslverr) else $error("no slave error");
  zero_bits_a: assert property (pready && !pwrite && paddr == 12'h020 |-> !(prdata & 32'hffff_cccc))
    else $error("reserved bits set");
  reset_out_a: assert property ($rose(presetn) |-> !chan_out) else $error("outputs after reset");
  off_level_a: assert property (!(chan_out.pin_level & ~chan_out.pin_oe)) else $error("off level");
  capture_mode_a: assert property (!(chan_out.capture_edge & chan_out.pin_oe)) else $error("capture");
  pin_follow_a: assert property (!$past(psel, 2) |-> !(chan_out.pin_oe & $past(chan_out.pin_oe)
    & (chan_out.pin_level ^ $past(chan_out.pin_level) ^ $past(chan_in.compare) ^ $past(chan_in.compare, 2))))
    else $error("pin level");
endmodule : chan_en_pol_checker
bind chan_en_pol chan_en_pol_checker i_chan_en_pol_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .paddr, .prdata, .chan_in, .chan_out);

// [tb/chan_pins_model.sv]
// Outside world that drives the channel input pins.
`timescale 1ns/1ps
module chan_pins_model (
  // Pin levels.
  input  wire logic [3:0] drive,
  output logic      [3:0] capture_in
);
  assign capture_in = drive;
endmodule : chan_pins_model

// [tb/test_chan_en_pol.sv]
// Self-checking bench for the channel enable and polarity block.
`timescale 1ns/1ps
module test_chan_en_pol import chan_en_pol_pkg::*; ;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clk_en = 1, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  cmp = 0, drive = 0, pins, caps = 0;
  logic        caps_clr = 0, err;
  chan_out_t   chan_out;
  int          err_total = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) caps <= caps_clr ? 4'h0 : (caps | chan_out.capture_edge);
  chan_en_pol i_chan_en_pol (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chan_in({cmp, pins}), .chan_out);
  chan_pins_model i_chan_pins_model (.drive, .capture_in(pins));
  task chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) $display("Error at %0t: %h, expected %h", $time, s, e);
    if (s !== e) err_total++;
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task stop_test;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task reg_test;
    apb(0, 12'h020, '0);
    chk(rd, 16'h0000);
    chk(err, 1'b0);
    apb(1, 12'h020, 32'hffff_ffff);
    apb(0, 12'h020, '0);
    chk(rd, 16'h3333);
    apb(0, 12'h030, '0);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    for (int l = 3; l >= 0; l--) begin
      apb(1, 12'h024, 32'(l));
      apb(1, 12'h020, '0);
      apb(0, 12'h020, '0);
      chk(rd, l > 1 ? 16'h2222 : 16'h0000);
    end
  endtask : reg_test
  task out_test;
    cmp <= 4'h5;
    apb(1, 12'h020, 16'h3131);
    repeat (2) @(negedge pclk);
    chk({chan_out.pin_oe, chan_out.pin_level}, 8'hff);
    @(posedge pclk) cmp <= 4'ha;
    repeat (2) @(negedge pclk);
    chk({chan_out.pin_oe, chan_out.pin_level}, 8'hf0);
    apb(1, 12'h020, 16'h2222);
    repeat (2) @(negedge pclk);
    chk({chan_out.pin_oe, chan_out.pin_level}, 8'h00);
  endtask : out_test
  // Lets pending edges from the register change drain before counting captures.
  task in_run(input logic [15:0] v, input logic [3:0] d, input logic [7:0] want);
    apb(1, 12'h020, v);
    caps_clr <= 1'b1;
    repeat (8) @(posedge pclk);
    caps_clr <= 1'b0;
    drive <= d;
    repeat (8) @(negedge pclk);
    chk({caps, chan_out.trigger}, want);
  endtask : in_run
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    reg_test;
    out_test;
    apb(1, 12'h028, 4'hf);
    in_run(16'h3131, 4'hf, 8'h55);
    in_run(16'h3131, 4'h0, 8'haa);
    in_run(16'h2323, 4'hf, 8'h00);
    in_run(16'h2323, 4'h0, 8'h5f);
    stop_test;
  end
  initial begin
    #20us;
    err_total++;
    stop_test;
  end
endmodule : test_chan_en_pol
